//--- pssd_pkg.sv
// package: constants, field layouts and state types for position source select/decode
// assumes: a single 40 MHz core clock; register port carries 32-bit words
package pssd_pkg;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] PSSD_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] PSSD_PPF_ADDR    = 8'h04;
   localparam logic [7:0] PSSD_START_ADDR  = 8'h08;
   localparam logic [7:0] PSSD_FWDUR_ADDR  = 8'h0c;
   localparam logic [7:0] PSSD_STATUS_ADDR = 8'h10;
   localparam logic [7:0] PSSD_POS_ADDR    = 8'h14;
   localparam logic [7:0] PSSD_TC_ADDR     = 8'h18;
   // ************************************************************
   // control fields
   // ************************************************************
   localparam int PSSD_CTRL_AUTO_BIT   = 0;
   localparam int PSSD_CTRL_QUAD_BIT   = 1;
   localparam int PSSD_CTRL_BLEADS_BIT = 2;
   localparam int PSSD_CTRL_TACHHI_BIT = 3;
   localparam int PSSD_CTRL_POSREF_BIT = 4;
   localparam int PSSD_CTRL_W          = 5;
   localparam logic [PSSD_CTRL_W-1:0] PSSD_CTRL_RST = 5'h03;
   // ************************************************************
   // reset values and widths
   // ************************************************************
   localparam int PSSD_PPF_W = 16;
   localparam logic [15:0] PSSD_PPF_RST   = 16'h0064;
   localparam int PSSD_POS_W = 24;
   localparam int PSSD_FW_W  = 8;
   localparam logic [7:0]  PSSD_FWDUR_RST = 8'h08;
   localparam int PSSD_SPD_W = 8;
   // speed in percent of 1x play; switch-over point
   localparam logic [7:0]  PSSD_SPEED_THRESH = 8'h4b;
   // ************************************************************
   // source selection
   // ************************************************************
   typedef enum logic [1:0] {
      PSSD_SRC_NONE,
      PSSD_SRC_LONG,
      PSSD_SRC_VERT
   } pssd_src_t;
   typedef enum logic [1:0] {
      PSSD_ST_IDLE,
      PSSD_ST_LOCK,
      PSSD_ST_FREE
   } pssd_st_t;
endpackage

//--- pssd_quad.sv
// quadrature / tach decoder: direction, pulse strobe and frame position
// assumes: a and b already synchronised to clk_i
`timescale 1ns/1ps
module pssd_quad
   import pssd_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // lines
   input  wire logic                  a_i,
   input  wire logic                  b_i,
   // setup
   input  wire logic                  quad_mode_i,
   input  wire logic                  b_leads_fwd_i,
   input  wire logic                  tach_hi_fwd_i,
   input  wire logic                  dir_used_i,
   input  wire logic [PSSD_PPF_W-1:0] ppf_i,
   input  wire logic                  load_i,
   input  wire logic [PSSD_POS_W-1:0] start_i,
   // results
   output logic                       fwd_o,
   output logic                       pulse_o,
   output logic                       frame_o,
   output logic [PSSD_POS_W-1:0]      pos_o
);
   logic                  a_q, b_q, fwd_q, pulse_q, frame_q;
   logic [PSSD_PPF_W-1:0] cnt_q;
   logic [PSSD_POS_W-1:0] pos_q;
   // lead detect from edge of a against level of b
   wire a_rise   = a_i & ~a_q;
   wire a_fall   = ~a_i & a_q;
   wire b_edge   = b_i ^ b_q;
   wire a_leads  = (a_rise & ~b_i) | (a_fall & b_i);
   wire quad_ev  = a_rise | a_fall | b_edge;
   // b edge: a already at b's new level means a went first
   wire quad_aw  = (a_rise | a_fall) ? a_leads : (b_i ~^ a_i);
   wire quad_fwd = quad_aw ^ b_leads_fwd_i;
   // tach: a is rate, b level is direction
   wire tach_fwd = b_i == tach_hi_fwd_i;
   wire ev       = quad_mode_i ? quad_ev : a_rise;
   wire dir_now  = quad_mode_i ? quad_fwd : tach_fwd;
   // direction only steers position when used as positional reference
   wire fwd_eff  = dir_used_i ? dir_now : 1'b1;
   wire wrap     = cnt_q >= ppf_i - 16'h0001;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         fwd_q <= 1'b1;
         pulse_q <= 1'b0;
         frame_q <= 1'b0;
         cnt_q <= '0;
         pos_q <= '0;
      end else begin
         a_q <= a_i;
         b_q <= b_i;
         // every a or b edge in quad mode, only a rises in tach mode, counts at any rate down to standstill
         pulse_q <= ev;
         frame_q <= 1'b0;
         // tach direction is a level, tracked without a pulse
         if (ev || !quad_mode_i) begin
            fwd_q <= fwd_eff;
         end
         // position loaded with starting frame when load_i is set, divider cleared
         if (load_i) begin
            pos_q <= start_i;
            cnt_q <= '0;
         end else if (ev) begin
            if (wrap) begin
               cnt_q <= '0;
               frame_q <= 1'b1;
               pos_q <= fwd_eff ? pos_q + 24'h000001 : pos_q - 24'h000001;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
      end
   end
   assign fwd_o   = fwd_q;
   assign pulse_o = pulse_q;
   assign frame_o = frame_q;
   assign pos_o   = pos_q;
endmodule

//--- pssd_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes: input is asynchronous to clk_i
`timescale 1ns/1ps
module pssd_sync3
   import pssd_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // data
   input  wire logic d_i,
   output logic      q_o
);
   logic s1_q, s2_q, s3_q, q_q;
   // first stage only feeds the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_q  <= 1'b0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q_q <= s3_q;
         end
      end
   end
   assign q_o = q_q;
endmodule

//--- pssd_top.sv
// top: time code source arbitration, freewheel and quadrature position front end
// assumes: readers deliver code words with valid strobes and a frame tick
`timescale 1ns/1ps
module pssd_top
   import pssd_pkg::*;
(
   // clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  nrst_i,
   // register port
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic [31:0]           reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic [31:0]                reg_rdata_o,
   // time code readers
   input  wire logic                  ltc_valid_i,
   input  wire logic [PSSD_POS_W-1:0] ltc_addr_i,
   input  wire logic                  vitc_valid_i,
   input  wire logic [PSSD_POS_W-1:0] vitc_addr_i,
   input  wire logic [PSSD_SPD_W-1:0] speed_pct_i,
   input  wire logic                  frame_tick_i,
   // transport pins
   input  wire logic                  line_a_i,
   input  wire logic                  line_b_i,
   // results
   output logic                       tc_valid_o,
   output logic [PSSD_POS_W-1:0]      tc_addr_o,
   output logic [1:0]                 tc_src_o,
   output logic                       clk_ref_o,
   output logic                       fwd_o,
   output logic [PSSD_POS_W-1:0]      pos_o
);
   // ************************************************************
   // reset release
   // ************************************************************
   logic rs1_q, rst_n;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rs1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_n <= rs1_q;
      end
   end
   // ************************************************************
   // registers
   // ************************************************************
   logic [PSSD_CTRL_W-1:0] ctrl_q;
   logic [PSSD_PPF_W-1:0]  ppf_q;
   logic [PSSD_POS_W-1:0]  start_q;
   logic [PSSD_FW_W-1:0]   fwdur_q;
   logic                   load_q;
   logic [31:0]            rdata_q;
   wire wr_ctrl  = reg_wr_i && reg_addr_i == PSSD_CTRL_ADDR;
   wire wr_ppf   = reg_wr_i && reg_addr_i == PSSD_PPF_ADDR;
   wire wr_start = reg_wr_i && reg_addr_i == PSSD_START_ADDR;
   wire wr_fwdur = reg_wr_i && reg_addr_i == PSSD_FWDUR_ADDR;
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= PSSD_CTRL_RST;
         ppf_q <= PSSD_PPF_RST;
         start_q <= '0;
         fwdur_q <= PSSD_FWDUR_RST;
         load_q <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata_i[PSSD_CTRL_W-1:0];
         // zero would wrap the divider only every 65536 edges, so keep the old value
         if (wr_ppf && reg_wdata_i[PSSD_PPF_W-1:0] != '0) begin
            ppf_q <= reg_wdata_i[PSSD_PPF_W-1:0];
         end
         if (wr_start) start_q <= reg_wdata_i[PSSD_POS_W-1:0];
         if (wr_fwdur) fwdur_q <= reg_wdata_i[PSSD_FW_W-1:0];
         // writing the start frame loads the position counter
         load_q <= wr_start;
      end
   end
   wire auto_en = ctrl_q[PSSD_CTRL_AUTO_BIT];
   wire quad_md = ctrl_q[PSSD_CTRL_QUAD_BIT];
   wire posref  = ctrl_q[PSSD_CTRL_POSREF_BIT];
   // ************************************************************
   // pin synchronisers and decoder
   // ************************************************************
   logic a_s, b_s, q_fwd, q_pulse, q_frame;
   logic [PSSD_POS_W-1:0] q_pos;
   pssd_sync3 u_sync_a (
      .clk_i   (core_clk_i),
      .rst_n_i (rst_n),
      .d_i     (line_a_i),
      .q_o     (a_s)
   );
   pssd_sync3 u_sync_b (
      .clk_i   (core_clk_i),
      .rst_n_i (rst_n),
      .d_i     (line_b_i),
      .q_o     (b_s)
   );
   pssd_quad u_quad (
      .clk_i         (core_clk_i),
      .rst_n_i       (rst_n),
      .a_i           (a_s),
      .b_i           (b_s),
      .quad_mode_i   (quad_md),
      .b_leads_fwd_i (ctrl_q[PSSD_CTRL_BLEADS_BIT]),
      .tach_hi_fwd_i (ctrl_q[PSSD_CTRL_TACHHI_BIT]),
      .dir_used_i    (posref),
      .ppf_i         (ppf_q),
      .load_i        (load_q),
      .start_i       (start_q),
      .fwd_o         (q_fwd),
      .pulse_o       (q_pulse),
      .frame_o       (q_frame),
      .pos_o         (q_pos)
   );
   // ************************************************************
   // source arbitration
   // ************************************************************
   pssd_st_t               st_q;
   pssd_src_t              src_q;
   logic [PSSD_FW_W-1:0]   fw_q;
   logic [PSSD_POS_W-1:0]  addr_q;
   logic                   tcv_q;
   logic                   fwd_q;
   logic                   clk_ref_q;
   logic [PSSD_POS_W-1:0]  pos_q;
   // preferred source from availability and speed
   wire fast = speed_pct_i > PSSD_SPEED_THRESH;
   wire pick_long = ltc_valid_i && (!vitc_valid_i || fast);
   wire pick_vert = vitc_valid_i && !pick_long;
   wire any_ok    = ltc_valid_i || vitc_valid_i;
   pssd_src_t pick;
   assign pick = pick_long ? PSSD_SRC_LONG : (pick_vert ? PSSD_SRC_VERT : PSSD_SRC_NONE);
   wire cur_ok = (src_q == PSSD_SRC_LONG && ltc_valid_i) ||
                 (src_q == PSSD_SRC_VERT && vitc_valid_i);
   wire manual_vert = !auto_en && vitc_valid_i;
   wire [PSSD_POS_W-1:0] cur_addr = (src_q == PSSD_SRC_LONG) ? ltc_addr_i : vitc_addr_i;
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= PSSD_ST_IDLE;
         src_q <= PSSD_SRC_NONE;
         fw_q <= '0;
         addr_q <= '0;
         tcv_q <= 1'b0;
      end else begin
         case (st_q)
            PSSD_ST_IDLE: begin
               tcv_q <= 1'b0;
               if (any_ok) begin
                  st_q <= PSSD_ST_LOCK;
                  src_q <= auto_en ? pick : (ltc_valid_i ? PSSD_SRC_LONG : PSSD_SRC_VERT);
               end
            end
            PSSD_ST_LOCK: begin
               if (cur_ok) begin
                  addr_q <= cur_addr;
                  tcv_q <= 1'b1;
                  if (auto_en && pick != src_q) src_q <= pick;
               end else begin
                  // dropout enters freewheel, no switch yet
                  st_q <= PSSD_ST_FREE;
                  fw_q <= fwdur_q;
               end
            end
            PSSD_ST_FREE: begin
               if (cur_ok) begin
                  st_q <= PSSD_ST_LOCK;
               end else if (fw_q == '0) begin
                  // switch only after expiry, else stop
                  tcv_q <= 1'b0;
                  if (auto_en && any_ok) begin
                     src_q <= pick;
                     st_q <= PSSD_ST_LOCK;
                  end else if (manual_vert && src_q == PSSD_SRC_NONE) begin
                     st_q <= PSSD_ST_LOCK;
                  end else begin
                     st_q <= PSSD_ST_IDLE;
                     src_q <= PSSD_SRC_NONE;
                  end
               end else if (frame_tick_i) begin
                  // flywheel the last address once per frame
                  fw_q <= fw_q - 8'h01;
                  addr_q <= addr_q + 24'h000001;
               end
            end
            default: begin
               st_q <= PSSD_ST_IDLE;
            end
         endcase
      end
   end
   // ************************************************************
   // outputs and read port
   // ************************************************************
   wire [31:0] status_w = {26'h0, q_fwd, tcv_q, st_q, src_q};
   logic [31:0] rd_w;
   always_comb begin
      case (reg_addr_i)
         PSSD_CTRL_ADDR:   rd_w = {27'h0, ctrl_q};
         PSSD_PPF_ADDR:    rd_w = {16'h0, ppf_q};
         PSSD_START_ADDR:  rd_w = {8'h0, start_q};
         PSSD_FWDUR_ADDR:  rd_w = {24'h0, fwdur_q};
         PSSD_STATUS_ADDR: rd_w = status_w;
         PSSD_POS_ADDR:    rd_w = {8'h0, q_pos};
         PSSD_TC_ADDR:     rd_w = {8'h0, addr_q};
         default:          rd_w = 32'h0;
      endcase
   end
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
         fwd_q <= 1'b1;
         clk_ref_q <= 1'b0;
         pos_q <= '0;
      end else begin
         rdata_q <= reg_rd_i ? rd_w : 32'h0;
         fwd_q <= q_fwd;
         // clock reference follows every decoder pulse, including b edges in quad mode
         clk_ref_q <= q_pulse;
         pos_q <= q_pos;
      end
   end
   assign reg_rdata_o = rdata_q;
   assign tc_valid_o  = tcv_q;
   assign tc_addr_o   = addr_q;
   assign tc_src_o    = src_q;
   assign clk_ref_o   = clk_ref_q;
   assign fwd_o       = fwd_q;
   assign pos_o       = pos_q;
   // ************************************************************
   // checks
   // ************************************************************
   property p_no_switch_in_free;
      @(posedge core_clk_i) disable iff (!rst_n)
      (st_q == PSSD_ST_FREE && fw_q != '0) |=> $stable(src_q);
   endproperty
   a_no_switch_in_free: assert property (p_no_switch_in_free)
      else $error("source changed during freewheel");
   property p_stop_when_none;
      @(posedge core_clk_i) disable iff (!rst_n)
      (st_q == PSSD_ST_FREE && fw_q == '0 && !any_ok) |=> !tcv_q;
   endproperty
   a_stop_when_none: assert property (p_stop_when_none)
      else $error("time code still valid with no source");
   property p_fast_long;
      @(posedge core_clk_i) disable iff (!rst_n)
      (auto_en && st_q == PSSD_ST_LOCK && cur_ok && ltc_valid_i && fast) |=> src_q == PSSD_SRC_LONG;
   endproperty
   a_fast_long: assert property (p_fast_long)
      else $error("long code not chosen at high speed");
   property p_slow_vert;
      @(posedge core_clk_i) disable iff (!rst_n)
      (auto_en && st_q == PSSD_ST_LOCK && cur_ok && vitc_valid_i && !fast) |=>
         src_q == PSSD_SRC_VERT;
   endproperty
   a_slow_vert: assert property (p_slow_vert)
      else $error("vertical code not chosen at low speed");
   property p_flywheel;
      @(posedge core_clk_i) disable iff (!rst_n)
      (st_q == PSSD_ST_FREE && !cur_ok && fw_q != '0 && frame_tick_i) |=>
         addr_q == $past(addr_q) + 24'h000001;
   endproperty
   a_flywheel: assert property (p_flywheel)
      else $error("freewheel address did not advance");
   property p_load;
      @(posedge core_clk_i) disable iff (!rst_n)
      wr_start |=> ##1 q_pos == $past(start_q, 1);
   endproperty
   a_load: assert property (p_load)
      else $error("start frame not loaded");
   property p_pos_step;
      @(posedge core_clk_i) disable iff (!rst_n)
      q_frame |-> (q_pos != $past(q_pos));
   endproperty
   a_pos_step: assert property (p_pos_step)
      else $error("frame strobe without position step");
   property p_clkref;
      @(posedge core_clk_i) disable iff (!rst_n)
      q_pulse |=> clk_ref_q;
   endproperty
   a_clkref: assert property (p_clkref)
      else $error("clock reference missed a pulse");
   c_free: cover property (@(posedge core_clk_i) disable iff (!rst_n)
      st_q == PSSD_ST_LOCK ##1 st_q == PSSD_ST_FREE);
   c_swap: cover property (@(posedge core_clk_i) disable iff (!rst_n)
      src_q == PSSD_SRC_LONG ##1 src_q == PSSD_SRC_VERT);
   c_frame: cover property (@(posedge core_clk_i) disable iff (!rst_n) q_frame);
endmodule

//--- pssd_top_bench.sv
// bench: register port driver, transport model and scenario tasks
// assumes: 40 MHz clock, register read data one cycle after the strobe
`timescale 1ns/1ps
module pssd_top_bench;
   import pssd_pkg::*;
   logic                  clk = 1'b0;
   logic                  nrst = 1'b0;
   logic [7:0]            addr = 8'h00;
   logic [31:0]           wdata = 32'h0;
   logic                  wr = 1'b0;
   logic                  rd = 1'b0;
   logic [31:0]           rdata;
   logic                  ltc_v, vitc_v, tick, la, lb, tcv, cref, fwd;
   logic [PSSD_POS_W-1:0] ltc_a, vitc_a, tca, pos;
   logic [7:0]            spd;
   logic [1:0]            src;
   int                    fail_count = 0;
   int                    samples_checked = 0;
   int                    refs = 0;
   int                    r0;
   logic [PSSD_POS_W-1:0] last;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (cref === 1'b1) refs++;
   pssd_transport pssd_transport_i (.clk_i(clk), .ltc_valid_o(ltc_v), .ltc_addr_o(ltc_a),
      .vitc_valid_o(vitc_v), .vitc_addr_o(vitc_a), .speed_pct_o(spd), .frame_tick_o(tick),
      .line_a_o(la), .line_b_o(lb));
   pssd_top pssd_top_i (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .ltc_valid_i(ltc_v), .ltc_addr_i(ltc_a), .vitc_valid_i(vitc_v),
      .vitc_addr_i(vitc_a), .speed_pct_i(spd), .frame_tick_i(tick), .line_a_i(la),
      .line_b_i(lb), .tc_valid_o(tcv), .tc_addr_o(tca), .tc_src_o(src),
      .clk_ref_o(cref), .fwd_o(fwd), .pos_o(pos));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(n, e, rdata);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk iff tick);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      chk("tc_valid", 32'h0, {31'h0, tcv});
      rd_chk(PSSD_CTRL_ADDR, 32'h3, "ctrl");
      rd_chk(PSSD_PPF_ADDR, 32'h64, "ppf");
      rd_chk(PSSD_FWDUR_ADDR, 32'h8, "fwdur");
      rd_chk(PSSD_STATUS_ADDR, 32'h20, "status");
      wr_reg(8'h40, 32'h5a);
      rd_chk(8'h40, 32'h0, "unmapped");
   endtask
   // speed exactly at the switch point counts as slow
   task automatic t_tc_slow;
      pssd_transport_i.set_tc(1'b1, 1'b1, 8'h4b);
      cyc(6);
      chk("src_slow", 32'h2, {30'h0, src}); // vertical at 75%
      pssd_transport_i.set_tc(1'b0, 1'b0, 8'h4b);
      ticks(2);
      cyc(2);
      chk("hold_src", 32'h2, {30'h0, src}); // hold during freewheel
      chk("hold_valid", 32'h1, {31'h0, tcv}); // still reading
      ticks(8);
      cyc(4);
      chk("stop_valid", 32'h0, {31'h0, tcv}); // readings stop
      chk("stop_src", 32'h0, {30'h0, src}); // no source
   endtask
   task automatic t_tc_fast;
      wr_reg(PSSD_FWDUR_ADDR, 32'h4);
      pssd_transport_i.set_tc(1'b1, 1'b1, 8'h64);
      cyc(6);
      chk("src_fast", 32'h1, {30'h0, src}); // longitudinal above 75%
      pssd_transport_i.set_tc(1'b0, 1'b1, 8'h64);
      last = pssd_transport_i.frm_q;
      ticks(3);
      cyc(2);
      chk("fw_src", 32'h1, {30'h0, src}); // no early switch
      chk("fw_adv", 32'h1, {31'h0, (tca - last >= 2) && (tca - last <= 3)}); // advance
      rd_chk(PSSD_STATUS_ADDR, 32'h39, "fw_status"); // freewheel state
      ticks(3);
      cyc(3);
      chk("to_vert", 32'h2, {30'h0, src}); // vertical after loss
      pssd_transport_i.set_tc(1'b0, 1'b0, 8'h64);
      ticks(6);
      cyc(3);
      chk("none_valid", 32'h0, {31'h0, tcv}); // readings stop
   endtask
   task automatic t_search;
      pssd_transport_i.set_tc(1'b1, 1'b0, 8'hc8);
      cyc(6);
      chk("search_src", 32'h1, {30'h0, src}); // longitudinal in search
      pssd_transport_i.set_tc(1'b0, 1'b0, 8'h00);
      ticks(6);
      cyc(3);
   endtask
   task automatic t_quad;
      wr_reg(PSSD_CTRL_ADDR, 32'h13);
      wr_reg(PSSD_PPF_ADDR, 32'h4);
      wr_reg(PSSD_START_ADDR, 32'h10); // controller supplies start
      cyc(4);
      chk("start", 32'h10, {8'h0, pos}); // start frame loaded
      r0 = refs;
      pssd_transport_i.move(4, 1'b1);
      cyc(8);
      chk("q_fwd_pos", 32'h11, {8'h0, pos}); // one frame per ppf
      chk("q_fwd", 32'h1, {31'h0, fwd}); // a leads is forward
      chk("q_refs", 32'h4, refs - r0); // every edge is a reference pulse
      pssd_transport_i.move(8, 1'b0);
      cyc(8);
      chk("q_rev_pos", 32'h0f, {8'h0, pos}); // reverse counts down
      chk("q_rev", 32'h0, {31'h0, fwd}); // b leads is reverse
      wr_reg(PSSD_CTRL_ADDR, 32'h17);
      pssd_transport_i.move(4, 1'b1);
      cyc(8);
      chk("pol_pos", 32'h0e, {8'h0, pos}); // polarity flipped
      chk("pol_fwd", 32'h0, {31'h0, fwd}); // polarity flipped
      wr_reg(PSSD_CTRL_ADDR, 32'h07);
      pssd_transport_i.move(4, 1'b1);
      cyc(8);
      chk("clkonly_fwd", 32'h1, {31'h0, fwd}); // direction ignored
      chk("clkonly_pos", 32'h0f, {8'h0, pos}); // direction ignored
   endtask
   task automatic t_tach;
      wr_reg(PSSD_CTRL_ADDR, 32'h11);
      wr_reg(PSSD_PPF_ADDR, 32'h0);
      rd_chk(PSSD_PPF_ADDR, 32'h4, "ppf_zero"); // zero refused
      wr_reg(PSSD_PPF_ADDR, 32'h2);
      pssd_transport_i.set_lines(1'b0, 1'b0);
      cyc(8);
      wr_reg(PSSD_START_ADDR, 32'h20); // controller supplies start
      cyc(4);
      r0 = refs;
      pssd_transport_i.pulse(4);
      cyc(8);
      chk("t_pos", 32'h22, {8'h0, pos}); // rate from line a
      chk("t_fwd", 32'h1, {31'h0, fwd}); // b low forward
      chk("t_refs", 32'h4, refs - r0); // rate line only
      pssd_transport_i.set_lines(1'b0, 1'b1);
      cyc(8);
      chk("t_rev", 32'h0, {31'h0, fwd}); // b high reverse
      chk("t_brefs", 32'h4, refs - r0); // b level not a clock
      pssd_transport_i.pulse(2);
      cyc(8);
      chk("t_rpos", 32'h21, {8'h0, pos}); // reverse counts down
      wr_reg(PSSD_CTRL_ADDR, 32'h19);
      cyc(8);
      chk("t_hifwd", 32'h1, {31'h0, fwd}); // b high forward
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // watchdog: the scenarios need about 1100 cycles
   initial begin
      repeat (8000) @(posedge clk);
      fail_count++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_tc_slow();
      t_tc_fast();
      t_search();
      t_quad();
      t_tach();
      results();
   end
endmodule

//--- pssd_transport.sv
// transport model: time code readers, frame tick and quadrature/tach lines
// assumes: one clock; the bench steers it through its tasks
`timescale 1ns/1ps
module pssd_transport
   import pssd_pkg::*;
(
   // clock
   input  wire logic             clk_i,
   // time code
   output logic                  ltc_valid_o,
   output logic [PSSD_POS_W-1:0] ltc_addr_o,
   output logic                  vitc_valid_o,
   output logic [PSSD_POS_W-1:0] vitc_addr_o,
   output logic [PSSD_SPD_W-1:0] speed_pct_o,
   output logic                  frame_tick_o,
   // lines
   output logic                  line_a_o,
   output logic                  line_b_o
);
   logic [PSSD_POS_W-1:0] frm_q = 24'h000100;
   logic [4:0]            div_q = 5'h00;
   logic                  ltc_on = 1'b0;
   logic                  vitc_on = 1'b0;
   logic [1:0]            ph = 2'h0;
   initial begin
      frame_tick_o = 1'b0;
      speed_pct_o = 8'h00;
      line_a_o = 1'b0;
      line_b_o = 1'b0;
   end
   // ****************************************
   // frame tick every 20 cycles
   // ****************************************
   always @(posedge clk_i) begin
      div_q <= (div_q == 5'h13) ? 5'h00 : div_q + 5'h01;
      frame_tick_o <= (div_q == 5'h13);
      if (div_q == 5'h13) begin
         frm_q <= frm_q + 24'h000001;
      end
   end
   // a silent reader shows no stale address
   assign ltc_valid_o = ltc_on;
   assign vitc_valid_o = vitc_on;
   assign ltc_addr_o = ltc_on ? frm_q : ~frm_q;
   assign vitc_addr_o = vitc_on ? frm_q : ~frm_q;
   task automatic set_tc(input logic l, input logic v, input logic [7:0] spd);
      @(posedge clk_i);
      ltc_on <= l;
      vitc_on <= v;
      speed_pct_o <= spd;
   endtask
   task automatic set_lines(input logic a, input logic b);
      @(posedge clk_i);
      line_a_o <= a;
      line_b_o <= b;
      ph = {b, a ^ b};
   endtask
   // quarter-cycle steps; a_lead walks 00,10,11,01
   task automatic move(input int n, input logic a_lead);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         ph = a_lead ? ph + 2'h1 : ph - 2'h1;
         line_a_o <= ph[1] ^ ph[0];
         line_b_o <= ph[1];
         repeat (11) @(posedge clk_i);
      end
   endtask
   // tach rate pulses on a, b left static
   task automatic pulse(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         line_a_o <= 1'b1;
         repeat (11) @(posedge clk_i);
         line_a_o <= 1'b0;
         repeat (11) @(posedge clk_i);
      end
   endtask
endmodule
